// ---- src/mart_pkg.sv ----
// Constants shared by the maintenance access and route table logic.
package mart_pkg;
	localparam int          NPORTS         = 16;
	localparam int          PORT_W         = 4;
	localparam int          NMCAST         = 8;
	localparam int          RT_DEPTH       = 256;
	localparam int          RT_ENTRY_W     = 8;
	// Packet field encodings.
	localparam logic [3:0]  FTYPE_MAINT    = 4'h8;
	localparam logic [1:0]  TT_LARGE       = 2'h1;
	localparam logic [3:0]  TTYPE_RD_REQ   = 4'h0;
	localparam logic [3:0]  TTYPE_WR_REQ   = 4'h1;
	localparam logic [3:0]  TTYPE_RD_RSP   = 4'h2;
	localparam logic [3:0]  TTYPE_WR_RSP   = 4'h3;
	localparam logic [7:0]  HOP_LOCAL      = 8'h00;
	localparam logic [7:0]  HOP_STEP       = 8'h01;
	localparam logic [7:0]  HOP_RSP        = 8'hFF;
	localparam logic [3:0]  STATUS_DONE    = 4'h0;
	localparam logic [1:0]  PRIO_MAX       = 2'h3;
	localparam logic [1:0]  PRIO_STEP      = 2'h1;
	localparam logic [7:0]  DOM_ZERO       = 8'h00;
	// Route table entry codes.
	localparam logic [7:0]  RT_MC_BASE     = 8'h40;
	localparam logic [7:0]  RT_FORCE_LOCAL = 8'hDD;
	localparam logic [7:0]  RT_DEFAULT     = 8'hDE;
	localparam logic [7:0]  RT_NO_ROUTE    = 8'hDF;
	// Route table window in the 21-bit configuration offset space.
	localparam logic [4:0]  RT_REGION      = 5'h0E;
	localparam int          RT_REGION_LSB  = 16;
	localparam int          RT_LOCAL_BIT   = 15;
	localparam int          RT_PORT_LSB    = 11;
	localparam int          RT_DOM_BIT     = 10;
	localparam int          RT_IDX_LSB     = 2;
	// Request spacing that must be serviced without loss.
	localparam int          CLK_PERIOD_NS  = 8;
	localparam int          SOP_SPACING_NS = 32;
	localparam int          SOP_SPACING_CYC = SOP_SPACING_NS / CLK_PERIOD_NS;
	typedef enum {ST_IDLE, ST_ACC, ST_RSP} mart_state_e;
endpackage

// ---- src/mart_rst_sync.sv ----
// Reset release synchroniser for the maintenance block.
`timescale 1ns/100ps
module mart_rst_sync (
	input  wire logic sys_clk_i,
	input  wire logic resetn_i,
	output logic      rst_n_o
);
	logic meta_q;

	// Assert at once, release two edges later so no flop sees a runt release.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q  <= 1'b0;
			rst_n_o <= 1'b0;
		end else begin
			meta_q  <= 1'b1;
			rst_n_o <= meta_q;
		end
	end
endmodule // mart_rst_sync

// ---- src/mart_route_tables.sv ----
// Global and per-port device and domain route tables with lookup.
`timescale 1ns/100ps
module mart_route_tables import mart_pkg::*; (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic [7:0]            domain_id_i,
	input  wire logic                  lk_valid_i,
	input  wire logic [PORT_W-1:0]     lk_port_i,
	input  wire logic                  lk_large_i,
	input  wire logic [15:0]           lk_dest_i,
	output logic                       lk_done_o,
	output logic [RT_ENTRY_W-1:0]      lk_entry_o,
	input  wire logic                  acc_en_i,
	input  wire logic                  acc_we_i,
	input  wire logic                  acc_local_i,
	input  wire logic [PORT_W-1:0]     acc_port_i,
	input  wire logic                  acc_dom_i,
	input  wire logic [7:0]            acc_idx_i,
	input  wire logic [RT_ENTRY_W-1:0] acc_wdata_i,
	output logic [RT_ENTRY_W-1:0]      acc_rdata_o,
	output logic                       init_busy_o
);
	logic [RT_ENTRY_W-1:0] gdev [RT_DEPTH];
	logic [RT_ENTRY_W-1:0] gdom [RT_DEPTH];
	logic [RT_ENTRY_W-1:0] dev_lk [NPORTS];
	logic [RT_ENTRY_W-1:0] dom_lk [NPORTS];
	logic [RT_ENTRY_W-1:0] dev_ac [NPORTS];
	logic [RT_ENTRY_W-1:0] dom_ac [NPORTS];
	logic                  init_q, init_d;
	logic [7:0]            init_idx_q, init_idx_d;
	logic                  wr_dev_g, wr_dom_g;
	logic [7:0]            wr_idx;
	logic [RT_ENTRY_W-1:0] wr_data;
	logic [7:0]            upper, lower;
	logic                  in_domain;
	logic                  done_d;
	logic [RT_ENTRY_W-1:0] entry_d, dom_hit;

	// Tables cannot be cleared in one edge, so a sweep loads the default route after reset.
	always_comb begin
		init_d     = init_q;
		init_idx_d = init_idx_q;
		if (init_q) begin
			init_idx_d = init_idx_q + 8'h01;
			if (init_idx_q == 8'hFF)
				init_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_q     <= 1'b1;
			init_idx_q <= 8'h00;
		end else begin
			init_q     <= init_d;
			init_idx_q <= init_idx_d;
		end
	end

	// A global write, or the reset sweep, lands in every table of its kind.
	always_comb begin
		wr_idx   = init_q ? init_idx_q : acc_idx_i;
		wr_data  = init_q ? RT_DEFAULT : acc_wdata_i;
		wr_dev_g = init_q | (acc_en_i & acc_we_i & !acc_local_i & !acc_dom_i);
		wr_dom_g = init_q | (acc_en_i & acc_we_i & !acc_local_i & acc_dom_i);
	end

	always_ff @(posedge sys_clk_i) begin
		if (wr_dev_g)
			gdev[wr_idx] <= wr_data;
		if (wr_dom_g)
			gdom[wr_idx] <= wr_data;
	end

	// Each port keeps its own pair of tables; global writes are replicated here.
	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		logic [RT_ENTRY_W-1:0] ldev [RT_DEPTH];
		logic [RT_ENTRY_W-1:0] ldom [RT_DEPTH];
		logic                  own;
		assign own = acc_en_i & acc_we_i & acc_local_i & (acc_port_i == PORT_W'(p));
		always_ff @(posedge sys_clk_i) begin
			if (wr_dev_g | (own & !acc_dom_i))
				ldev[wr_idx] <= wr_data;
			if (wr_dom_g | (own & acc_dom_i))
				ldom[wr_idx] <= wr_data;
		end
		assign dev_lk[p] = ldev[lower];
		assign dom_lk[p] = ldom[upper];
		assign dev_ac[p] = ldev[acc_idx_i];
		assign dom_ac[p] = ldom[acc_idx_i];
	end

	// Control-plane read: global locations answer from the global copy.
	always_comb begin
		if (acc_local_i)
			acc_rdata_o = acc_dom_i ? dom_ac[acc_port_i] : dev_ac[acc_port_i];
		else
			acc_rdata_o = acc_dom_i ? gdom[acc_idx_i] : gdev[acc_idx_i];
	end

	// Lookup always uses the arrival port's local tables.
	always_comb begin
		upper     = lk_large_i ? lk_dest_i[15:8] : DOM_ZERO;
		lower     = lk_dest_i[7:0];
		in_domain = (upper == DOM_ZERO) || (upper == domain_id_i);
		dom_hit   = dom_lk[lk_port_i];
		if (in_domain || dom_hit == RT_FORCE_LOCAL)
			entry_d = dev_lk[lk_port_i];
		else
			entry_d = dom_hit;
		done_d = lk_valid_i & !init_q;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lk_done_o  <= 1'b0;
			lk_entry_o <= RT_DEFAULT;
		end else begin
			lk_done_o  <= done_d;
			lk_entry_o <= entry_d;
		end
	end

	assign init_busy_o = init_q;
endmodule // mart_route_tables

// ---- src/mart_maint.sv ----
// Maintenance packet decode, local access, response build and forward decision.
`timescale 1ns/100ps
// Notes on behaviour
// - Format type 0b1000 marks a maintenance packet.
// - Hop count zero: consume and perform the register or memory access.
// - Nonzero hop: decrement by one, regenerate CRC, forward onward.
// - Transport type selects 8-bit or 16-bit destination identifier.
// - Local request with transaction other than 0 or 1 is dropped and flagged.
// - Local requests reach standard registers, other registers and memories.
// - Each response carries hop count 0xFF.
// - Response leaves on the port the request arrived on.
// - Critical flow bit is copied and otherwise ignored.
// - Reserved, tt, ftype copied; target TID equals request source TID.
// - Response priority is request plus one, saturating at 3.
// - Response destination and source IDs are swapped from the request.
// - Response transaction is the matching response type, status 0b0000.
// - Read responses carry the read data.
// - Local route table accesses spaced 32 ns apart are all serviced; external accesses wait for cfg_ack_i.
// - Every packet's destination is looked up in the route tables.
// - One destination may map to several output ports for multicast.
// - Device and domain tables, 256 entries of 8 bits each.
// - All tables read and write through control-plane accesses.
// - Global tables plus per-port local tables; global writes replicate.
// - Reads of global locations return the global table contents.
// - Forwarded maintenance packets use the arrival port's local tables.
// - Upper byte zero or matching domain uses device table, else domain table; a domain entry of RT_FORCE_LOCAL also selects the device table.
// - After reset every entry holds the default route.
module mart_maint import mart_pkg::*; (
	input  wire logic                  sys_clk_i,
	input  wire logic                  resetn_i,
	input  wire logic [7:0]            domain_id_i,
	input  wire logic [PORT_W-1:0]     default_port_i,
	input  wire logic [NMCAST*NPORTS-1:0] mc_masks_i,
	input  wire logic                  rx_valid_i,
	input  wire logic [PORT_W-1:0]     rx_port_i,
	input  wire logic [1:0]            rx_rsvd_i,
	input  wire logic                  rx_crf_i,
	input  wire logic [1:0]            rx_prio_i,
	input  wire logic [1:0]            rx_tt_i,
	input  wire logic [3:0]            rx_ftype_i,
	input  wire logic [15:0]           rx_dest_id_i,
	input  wire logic [15:0]           rx_src_id_i,
	input  wire logic [3:0]            rx_ttype_i,
	input  wire logic [3:0]            rx_size_i,
	input  wire logic [7:0]            rx_tid_i,
	input  wire logic [7:0]            rx_hop_i,
	input  wire logic [20:0]           rx_offset_i,
	input  wire logic [31:0]           rx_wdata_i,
	output logic                       rx_ready_o,
	output logic                       fwd_valid_o,
	output logic [PORT_W-1:0]          fwd_src_port_o,
	output logic [NPORTS-1:0]          fwd_port_mask_o,
	output logic [7:0]                 fwd_hop_o,
	output logic                       fwd_crc_regen_o,
	output logic                       err_bad_ttype_o,
	output logic                       cfg_req_o,
	output logic                       cfg_we_o,
	output logic [20:0]                cfg_addr_o,
	output logic [31:0]                cfg_wdata_o,
	input  wire logic                  cfg_ack_i,
	input  wire logic [31:0]           cfg_rdata_i,
	output logic                       rsp_valid_o,
	output logic [PORT_W-1:0]          rsp_port_o,
	output logic [1:0]                 rsp_rsvd_o,
	output logic                       rsp_crf_o,
	output logic [1:0]                 rsp_prio_o,
	output logic [1:0]                 rsp_tt_o,
	output logic [3:0]                 rsp_ftype_o,
	output logic [15:0]                rsp_dest_id_o,
	output logic [15:0]                rsp_src_id_o,
	output logic [3:0]                 rsp_ttype_o,
	output logic [3:0]                 rsp_status_o,
	output logic [7:0]                 rsp_tid_o,
	output logic [7:0]                 rsp_hop_o,
	output logic [31:0]                rsp_rdata_o
);
	localparam int SVC_CYC = SOP_SPACING_CYC;

	logic                  rst_n;
	logic                  take, is_maint, is_local, ttype_ok;
	logic                  lk_done, init_busy;
	logic [RT_ENTRY_W-1:0] lk_entry, acc_rdata;
	logic                  tbl_hit, acc_done, tbl_en;
	mart_state_e           st_q, st_d;
	logic                  ready_q, ready_d, err_q, err_d;
	logic                  creq_q, creq_d;
	// Captured request.
	logic [PORT_W-1:0]     r_port_q, r_port_d;
	logic [1:0]            r_rsvd_q, r_rsvd_d, r_prio_q, r_prio_d, r_tt_q, r_tt_d;
	logic                  r_crf_q, r_crf_d, r_rd_q, r_rd_d;
	logic [15:0]           r_dest_q, r_dest_d, r_src_q, r_src_d;
	logic [7:0]            r_tid_q, r_tid_d;
	logic [20:0]           r_off_q, r_off_d;
	logic [31:0]           r_wdata_q, r_wdata_d, rdata_q, rdata_d;
	// Forward pipeline stage alongside the table lookup.
	logic                  p1_fwd_q, p1_fwd_d, p1_maint_q, p1_maint_d;
	logic [PORT_W-1:0]     p1_port_q, p1_port_d;
	logic [7:0]            p1_hop_q, p1_hop_d;
	logic                  fv_q, fv_d, fcrc_q, fcrc_d;
	logic [PORT_W-1:0]     fport_q, fport_d;
	logic [NPORTS-1:0]     fmask_q, fmask_d;
	logic [7:0]            fhop_q, fhop_d;
	logic                  rv_q, rv_d;

	mart_rst_sync u_rst (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.rst_n_o   (rst_n)
	);

	mart_route_tables u_rt (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n),
		.domain_id_i (domain_id_i),
		.lk_valid_i  (take),
		.lk_port_i   (rx_port_i),
		.lk_large_i  (rx_tt_i == TT_LARGE),
		.lk_dest_i   (rx_dest_id_i),
		.lk_done_o   (lk_done),
		.lk_entry_o  (lk_entry),
		.acc_en_i    (tbl_en),
		.acc_we_i    (!r_rd_q),
		.acc_local_i (r_off_q[RT_LOCAL_BIT]),
		.acc_port_i  (r_off_q[RT_PORT_LSB +: PORT_W]),
		.acc_dom_i   (r_off_q[RT_DOM_BIT]),
		.acc_idx_i   (r_off_q[RT_IDX_LSB +: 8]),
		.acc_wdata_i (r_wdata_q[RT_ENTRY_W-1:0]),
		.acc_rdata_o (acc_rdata),
		.init_busy_o (init_busy)
	);

	// Packet classification at the intake.
	always_comb begin
		take     = rx_valid_i & ready_q;
		is_maint = rx_ftype_i == FTYPE_MAINT;
		is_local = is_maint & (rx_hop_i == HOP_LOCAL);
		ttype_ok = (rx_ttype_i == TTYPE_RD_REQ) || (rx_ttype_i == TTYPE_WR_REQ);
		tbl_hit  = r_off_q[20:RT_REGION_LSB] == RT_REGION;
		tbl_en   = (st_q == ST_ACC) & tbl_hit;
		acc_done = tbl_hit | cfg_ack_i;
	end

	// Local access sequencer; the table window is served inside, the rest goes out.
	always_comb begin
		st_d      = st_q;
		err_d     = 1'b0;
		creq_d    = 1'b0;
		rv_d      = 1'b0;
		rdata_d   = rdata_q;
		r_port_d  = r_port_q;
		r_rsvd_d  = r_rsvd_q;
		r_prio_d  = r_prio_q;
		r_tt_d    = r_tt_q;
		r_crf_d   = r_crf_q;
		r_rd_d    = r_rd_q;
		r_dest_d  = r_dest_q;
		r_src_d   = r_src_q;
		r_tid_d   = r_tid_q;
		r_off_d   = r_off_q;
		r_wdata_d = r_wdata_q;
		unique case (st_q)
			ST_IDLE: begin
				if (take && is_local && !ttype_ok) begin
					err_d = 1'b1;
				end else if (take && is_local) begin
					st_d      = ST_ACC;
					r_port_d  = rx_port_i;
					r_rsvd_d  = rx_rsvd_i;
					r_prio_d  = rx_prio_i;
					r_tt_d    = rx_tt_i;
					r_crf_d   = rx_crf_i;
					r_rd_d    = rx_ttype_i == TTYPE_RD_REQ;
					r_dest_d  = rx_dest_id_i;
					r_src_d   = rx_src_id_i;
					r_tid_d   = rx_tid_i;
					r_off_d   = rx_offset_i;
					r_wdata_d = rx_wdata_i;
					creq_d    = rx_offset_i[20:RT_REGION_LSB] != RT_REGION;
				end
			end
			ST_ACC: begin
				creq_d = creq_q & !cfg_ack_i;
				if (acc_done) begin
					st_d    = ST_RSP;
					rv_d    = 1'b1;
					rdata_d = tbl_hit ? {24'h000000, acc_rdata} : cfg_rdata_i;
				end
			end
			ST_RSP: begin
				st_d = ST_IDLE;
			end
		endcase
		ready_d = (st_d == ST_IDLE) & !init_busy;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= ST_IDLE;
			ready_q   <= 1'b0;
			err_q     <= 1'b0;
			creq_q    <= 1'b0;
			rv_q      <= 1'b0;
			rdata_q   <= 32'h00000000;
			r_port_q  <= '0;
			r_rsvd_q  <= 2'h0;
			r_prio_q  <= 2'h0;
			r_tt_q    <= 2'h0;
			r_crf_q   <= 1'b0;
			r_rd_q    <= 1'b0;
			r_dest_q  <= 16'h0000;
			r_src_q   <= 16'h0000;
			r_tid_q   <= 8'h00;
			r_off_q   <= 21'h000000;
			r_wdata_q <= 32'h00000000;
		end else begin
			st_q      <= st_d;
			ready_q   <= ready_d;
			err_q     <= err_d;
			creq_q    <= creq_d;
			rv_q      <= rv_d;
			rdata_q   <= rdata_d;
			r_port_q  <= r_port_d;
			r_rsvd_q  <= r_rsvd_d;
			r_prio_q  <= r_prio_d;
			r_tt_q    <= r_tt_d;
			r_crf_q   <= r_crf_d;
			r_rd_q    <= r_rd_d;
			r_dest_q  <= r_dest_d;
			r_src_q   <= r_src_d;
			r_tid_q   <= r_tid_d;
			r_off_q   <= r_off_d;
			r_wdata_q <= r_wdata_d;
		end
	end

	// Forward decision: entry codes become a port mask one edge after the lookup.
	always_comb begin
		p1_fwd_d   = take & !is_local;
		p1_maint_d = is_maint;
		p1_port_d  = rx_port_i;
		p1_hop_d   = is_maint ? rx_hop_i - HOP_STEP : rx_hop_i;
		fv_d       = p1_fwd_q & lk_done;
		fcrc_d     = fv_d & p1_maint_q;
		fport_d    = p1_port_q;
		fhop_d     = p1_hop_q;
		fmask_d    = '0;
		if (lk_entry < RT_ENTRY_W'(NPORTS))
			fmask_d[lk_entry[PORT_W-1:0]] = 1'b1;
		else if (lk_entry >= RT_MC_BASE && lk_entry < RT_MC_BASE + RT_ENTRY_W'(NMCAST))
			fmask_d = mc_masks_i[lk_entry[2:0]*NPORTS +: NPORTS];
		else if (lk_entry == RT_DEFAULT)
			fmask_d[default_port_i] = 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			p1_fwd_q   <= 1'b0;
			p1_maint_q <= 1'b0;
			p1_port_q  <= '0;
			p1_hop_q   <= 8'h00;
			fv_q       <= 1'b0;
			fcrc_q     <= 1'b0;
			fport_q    <= '0;
			fhop_q     <= 8'h00;
			fmask_q    <= '0;
		end else begin
			p1_fwd_q   <= p1_fwd_d;
			p1_maint_q <= p1_maint_d;
			p1_port_q  <= p1_port_d;
			p1_hop_q   <= p1_hop_d;
			fv_q       <= fv_d;
			fcrc_q     <= fcrc_d;
			fport_q    <= fport_d;
			fhop_q     <= fhop_d;
			fmask_q    <= fmask_d;
		end
	end

	// Response header is built from the captured request; it stands until the next one.
	assign rx_ready_o      = ready_q;
	assign err_bad_ttype_o = err_q;
	assign cfg_req_o       = creq_q;
	assign cfg_we_o        = !r_rd_q;
	assign cfg_addr_o      = r_off_q;
	assign cfg_wdata_o     = r_wdata_q;
	assign fwd_valid_o     = fv_q;
	assign fwd_src_port_o  = fport_q;
	assign fwd_port_mask_o = fmask_q;
	assign fwd_hop_o       = fhop_q;
	assign fwd_crc_regen_o = fcrc_q;
	assign rsp_valid_o     = rv_q;
	assign rsp_port_o      = r_port_q;
	assign rsp_rsvd_o      = r_rsvd_q;
	assign rsp_crf_o       = r_crf_q;
	assign rsp_prio_o      = (r_prio_q == PRIO_MAX) ? PRIO_MAX : r_prio_q + PRIO_STEP;
	assign rsp_tt_o        = r_tt_q;
	assign rsp_ftype_o     = FTYPE_MAINT;
	assign rsp_dest_id_o   = r_src_q;
	assign rsp_src_id_o    = r_dest_q;
	assign rsp_ttype_o     = r_rd_q ? TTYPE_RD_RSP : TTYPE_WR_RSP;
	assign rsp_status_o    = STATUS_DONE;
	assign rsp_tid_o       = r_tid_q;
	assign rsp_hop_o       = HOP_RSP;
	assign rsp_rdata_o     = rdata_q;

	// Checks on the sequencing and on the response built from each request.
	property p_nonmaint_fwd;
		@(posedge sys_clk_i) disable iff (!rst_n)
		take && !is_maint |-> ##2 fwd_valid_o && !fwd_crc_regen_o && fwd_hop_o == $past(rx_hop_i, 2);
	endproperty
	a_nonmaint_fwd: assert property (p_nonmaint_fwd) else $error("non-maintenance forward wrong");
	property p_local_take;
		@(posedge sys_clk_i) disable iff (!rst_n)
		take && is_local && ttype_ok |=> st_q == ST_ACC && !fwd_valid_o ##1 !fwd_valid_o;
	endproperty
	a_local_take: assert property (p_local_take) else $error("local request not consumed");
	property p_fwd_hop;
		@(posedge sys_clk_i) disable iff (!rst_n)
		take && is_maint && !is_local |-> ##2 fwd_valid_o && fwd_crc_regen_o && fwd_hop_o == $past(rx_hop_i, 2) - HOP_STEP;
	endproperty
	a_fwd_hop: assert property (p_fwd_hop) else $error("forwarded hop count wrong");
	property p_bad_ttype;
		@(posedge sys_clk_i) disable iff (!rst_n)
		take && is_local && !ttype_ok |=> err_bad_ttype_o && st_q == ST_IDLE ##1 !rsp_valid_o;
	endproperty
	a_bad_ttype: assert property (p_bad_ttype) else $error("bad transaction not discarded");
	property p_rsp_fields;
		@(posedge sys_clk_i) disable iff (!rst_n)
		rsp_valid_o |-> rsp_hop_o == HOP_RSP && rsp_status_o == STATUS_DONE && rsp_dest_id_o == r_src_q;
	endproperty
	a_rsp_fields: assert property (p_rsp_fields) else $error("response header wrong");
	property p_rsp_prio;
		@(posedge sys_clk_i) disable iff (!rst_n)
		rsp_valid_o |-> rsp_prio_o == (r_prio_q == PRIO_MAX ? PRIO_MAX : r_prio_q + PRIO_STEP);
	endproperty
	a_rsp_prio: assert property (p_rsp_prio) else $error("response priority wrong");
	property p_rsp_type;
		@(posedge sys_clk_i) disable iff (!rst_n)
		take && is_local && ttype_ok && rx_ttype_i == TTYPE_RD_REQ |=> (rsp_ttype_o == TTYPE_RD_RSP) [*2];
	endproperty
	a_rsp_type: assert property (p_rsp_type) else $error("read request lost its type");
	property p_svc_time;
		@(posedge sys_clk_i) disable iff (!rst_n)
		st_q == ST_ACC && tbl_hit |-> ##[1:SVC_CYC] rx_ready_o;
	endproperty
	a_svc_time: assert property (p_svc_time) else $error("local service too slow");
	c_read: cover property (@(posedge sys_clk_i) disable iff (!rst_n) rsp_valid_o && r_rd_q);
	c_write: cover property (@(posedge sys_clk_i) disable iff (!rst_n) rsp_valid_o && !r_rd_q);
	c_fwd: cover property (@(posedge sys_clk_i) disable iff (!rst_n) fwd_valid_o && fwd_crc_regen_o);
	c_bad: cover property (@(posedge sys_clk_i) disable iff (!rst_n) err_bad_ttype_o);
endmodule // mart_maint

// ---- bench/mart_cfg_model.sv ----
// Far-side register space that answers the block's external configuration accesses.
`timescale 1ns/100ps
module mart_cfg_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [20:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic             ack_o,
	output logic [31:0]      rdata_o
);
	logic [31:0] mem [0:15];
	logic        slow = 1'b0;
	int          cnt = 0;
	// Answers alternate prompt and slow; the data lines toggle between answers so stale data never looks valid.
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o) begin
			if (cnt == (slow ? 3 : 0)) begin
				ack_o <= 1'b1;
				cnt <= 0;
				slow <= ~slow;
				if (we_i)
					mem[addr_i[5:2]] <= wdata_i;
				rdata_o <= we_i ? ~rdata_o : mem[addr_i[5:2]];
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
	// Idle levels at time zero.
	initial begin
		ack_o = 1'b0;
		rdata_o = 32'h5A5A5A5A;
	end
endmodule // mart_cfg_model

// ---- bench/tb.sv ----
// Self-checking bench for the maintenance decode and route table block.
`timescale 1ns/100ps
module tb import mart_pkg::*;;
	logic        clk, resetn, rx_valid, rx_ready, fwd_valid, fwd_crc, err, cfg_req, cfg_we, cfg_ack, rsp_valid, rsp_crf;
	logic [3:0]  rx_port, rx_ftype, rx_ttype, fwd_src, rsp_port, rsp_ftype, rsp_ttype, rsp_status;
	logic [1:0]  rx_prio, rx_tt, rsp_rsvd, rsp_prio, rsp_tt;
	logic [15:0] rx_dest, rx_src, fwd_mask, rsp_dest, rsp_src;
	logic [7:0]  dom_id, rx_hop, fwd_hop, rsp_tid, rsp_hop;
	logic [20:0] rx_off, cfg_addr;
	logic [31:0] rx_wdata, cfg_wdata, cfg_rdata, rsp_rdata;
	logic [127:0] masks;
	int          failures = 0;
	int          checks = 0;
	// Device under test; default port, reserved bits, tag and size are held constant; the flow bit follows priority bit 0.
	mart_maint u_dut (.sys_clk_i(clk), .resetn_i(resetn), .domain_id_i(dom_id), .default_port_i(4'h6),
		.mc_masks_i(masks), .rx_valid_i(rx_valid), .rx_port_i(rx_port), .rx_rsvd_i(2'h2), .rx_crf_i(rx_prio[0]),
		.rx_prio_i(rx_prio), .rx_tt_i(rx_tt), .rx_ftype_i(rx_ftype), .rx_dest_id_i(rx_dest), .rx_src_id_i(rx_src),
		.rx_ttype_i(rx_ttype), .rx_size_i(4'h0), .rx_tid_i(8'hA5), .rx_hop_i(rx_hop), .rx_offset_i(rx_off),
		.rx_wdata_i(rx_wdata), .rx_ready_o(rx_ready), .fwd_valid_o(fwd_valid), .fwd_src_port_o(fwd_src),
		.fwd_port_mask_o(fwd_mask), .fwd_hop_o(fwd_hop), .fwd_crc_regen_o(fwd_crc), .err_bad_ttype_o(err),
		.cfg_req_o(cfg_req), .cfg_we_o(cfg_we), .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata), .cfg_ack_i(cfg_ack),
		.cfg_rdata_i(cfg_rdata), .rsp_valid_o(rsp_valid), .rsp_port_o(rsp_port), .rsp_rsvd_o(rsp_rsvd),
		.rsp_crf_o(rsp_crf), .rsp_prio_o(rsp_prio), .rsp_tt_o(rsp_tt), .rsp_ftype_o(rsp_ftype),
		.rsp_dest_id_o(rsp_dest), .rsp_src_id_o(rsp_src), .rsp_ttype_o(rsp_ttype), .rsp_status_o(rsp_status),
		.rsp_tid_o(rsp_tid), .rsp_hop_o(rsp_hop), .rsp_rdata_o(rsp_rdata));
	// Register space behind the external access port.
	mart_cfg_model u_cfg (.clk_i(clk), .req_i(cfg_req), .we_i(cfg_we), .addr_i(cfg_addr), .wdata_i(cfg_wdata),
		.ack_o(cfg_ack), .rdata_o(cfg_rdata));
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic results();
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Offers one header once ready, then reports 1 response, 2 forward, 3 discard or 0 nothing.
	task automatic send(input logic [3:0] p, ft, tty, input logic [1:0] pr, tt, input logic [15:0] d,
		input logic [7:0] h, input logic [20:0] o, input logic [31:0] w, output int k);
		int n;
		n = 0;
		while (rx_ready !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		{rx_port, rx_ftype, rx_ttype, rx_prio, rx_tt, rx_dest, rx_hop, rx_off, rx_wdata} = {p, ft, tty, pr, tt, d, h, o, w};
		rx_valid = 1'b1;
		@(posedge clk);
		#1 rx_valid = 1'b0;
		k = 0;
		for (n = 0; n < 20 && k == 0; n++) begin
			k = (rsp_valid === 1'b1) ? 1 : (fwd_valid === 1'b1) ? 2 : (err === 1'b1) ? 3 : 0;
			if (k == 0) begin
				@(posedge clk);
				#1;
			end
		end
	endtask
	// Writes or reads one route table entry; a read must return the given value.
	task automatic tbl(input logic we, loc, input logic [3:0] p, input logic dm, input logic [7:0] ix, v);
		int k;
		send(4'h9, FTYPE_MAINT, {3'h0, we}, 2'h1, 2'h0, 16'h0044, 8'h00,
			{RT_REGION, loc, p, dm, ix, 2'h0}, {24'h0, v}, k);
		chk(k, 1);
		if (!we)
			chk(rsp_rdata, {24'h0, v});
	endtask
	// Sends a maintenance packet with hop count 5 and checks the forward decision.
	task automatic fwd(input logic [3:0] p, input logic [1:0] tt, input logic [15:0] d, m);
		int k;
		send(p, FTYPE_MAINT, TTYPE_RD_REQ, 2'h0, tt, d, 8'h05, 21'h0, 32'h0, k);
		chk(k, 2);
		chk(fwd_mask, m);
		chk({fwd_hop, fwd_crc, fwd_src}, {8'h04, 1'b1, p});
	endtask
	// Every priority, with reset table contents read back through the response.
	task automatic t_header();
		int k;
		for (int pr = 0; pr < 4; pr++) begin
			send(4'hB, FTYPE_MAINT, TTYPE_RD_REQ, pr[1:0], TT_LARGE, 16'hABCD, 8'h00, {RT_REGION, 16'h0014}, 32'h0, k);
			chk(k, 1);
			chk(rsp_port, 4'hB);
			chk(rsp_prio, (pr == 3) ? 2'h3 : pr[1:0] + 2'h1);
			chk({rsp_dest, rsp_src}, {rx_src, 16'hABCD});
			chk({rsp_ttype, rsp_status}, {TTYPE_RD_RSP, 4'h0});
			chk(rsp_hop, 8'hFF);
			chk(rsp_crf, pr[0]);
			chk({rsp_rsvd, rsp_tt, rsp_ftype, rsp_tid}, {2'h2, TT_LARGE, 4'h8, 8'hA5});
			chk(rsp_rdata, {24'h0, RT_DEFAULT});
		end
	endtask
	// Global replication, local overrides, multicast and no-route entries.
	task automatic t_tables();
		tbl(1'b1, 1'b0, 4'h0, 1'b0, 8'h12, 8'h03);
		tbl(1'b0, 1'b1, 4'h7, 1'b0, 8'h12, 8'h03);
		fwd(4'h7, 2'h0, 16'h0012, 16'h0008);
		tbl(1'b1, 1'b1, 4'h7, 1'b0, 8'h12, 8'h41);
		fwd(4'h7, 2'h0, 16'h0012, 16'h8021);
		fwd(4'h2, 2'h0, 16'h0012, 16'h0008);
		tbl(1'b0, 1'b0, 4'h0, 1'b0, 8'h12, 8'h03);
		fwd(4'h2, 2'h0, 16'h0077, 16'h0040);
		tbl(1'b1, 1'b1, 4'h2, 1'b0, 8'h20, RT_NO_ROUTE);
		fwd(4'h2, 2'h0, 16'h0020, 16'h0000);
	endtask
	// Wide identifiers through the domain tables, including force-local.
	task automatic t_domain();
		fwd(4'h7, TT_LARGE, 16'h5A12, 16'h8021);
		fwd(4'h7, TT_LARGE, 16'h0012, 16'h8021);
		fwd(4'h2, TT_LARGE, 16'h3312, 16'h0040);
		tbl(1'b1, 1'b0, 4'h0, 1'b1, 8'h33, RT_FORCE_LOCAL);
		fwd(4'h2, TT_LARGE, 16'h3312, 16'h0008);
		fwd(4'h2, 2'h0, 16'h3312, 16'h0008);
		tbl(1'b1, 1'b1, 4'h2, 1'b1, 8'h34, 8'h09);
		fwd(4'h2, TT_LARGE, 16'h3412, 16'h0200);
	endtask
	// External accesses, a bad transaction code and a non-maintenance packet.
	task automatic t_misc();
		int k;
		send(4'h3, FTYPE_MAINT, TTYPE_WR_REQ, 2'h0, 2'h0, 16'h0044, 8'h00, 21'h000108, 32'hC0DE1234, k);
		chk({k[3:0], rsp_ttype}, {4'h1, TTYPE_WR_RSP});
		send(4'h3, FTYPE_MAINT, TTYPE_RD_REQ, 2'h0, 2'h0, 16'h0044, 8'h00, 21'h000108, 32'h0, k);
		chk(rsp_rdata, 32'hC0DE1234);
		send(4'h3, FTYPE_MAINT, 4'h5, 2'h0, 2'h0, 16'h0044, 8'h00, 21'h000108, 32'h0, k);
		chk(k, 3);
		send(4'h2, 4'h5, TTYPE_RD_REQ, 2'h0, 2'h0, 16'h0077, 8'h00, 21'h0, 32'h0, k);
		chk({k[3:0], fwd_crc, fwd_hop}, {4'h2, 1'b0, 8'h00});
	endtask
	// Reset, then the scenarios in turn.
	initial begin
		{resetn, rx_valid, rx_port, rx_ftype, rx_ttype, rx_prio, rx_tt, rx_dest, rx_hop, rx_off, rx_wdata} = '0;
		rx_src = 16'h01C3;
		dom_id = 8'h5A;
		for (int i = 0; i < 8; i++)
			masks[16*i+:16] = 16'h8001 | (16'h0010 << i);
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		t_header();
		t_tables();
		t_domain();
		t_misc();
		results();
	end
	// Watchdog well past the expected several hundred cycles.
	initial begin
		#100000 failures++;
		results();
	end
	// Free-running 125 MHz clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
endmodule // tb
